// ### pdcc_pkg.sv
// Package for the power-down and clock control block
package pdcc_pkg;
  // ==========================================
  // Register map
  localparam logic [15:0] PDCC_SYSTEM_CONTROL_POWER_ADDR = 16'hfff2;
  localparam logic [7:0] PDCC_SYSTEM_CONTROL_POWER_RESET = 8'h0b;
  localparam int PDCC_STANDBY_SELECT_BIT = 7;
  localparam int PDCC_STS_HI = 6;
  localparam int PDCC_STS_LO = 4;
  localparam int PDCC_RAM_ENABLE_BIT = 0;
  // ==========================================
  // Timing
  localparam int PDCC_PRESC_W = 12;
  localparam int PDCC_SETTLE_W = 18;
  localparam logic [17:0] PDCC_WAIT_BASE = 18'h0_2000;
  localparam int PDCC_DUTY_MHZ = 5;
  localparam int PDCC_CLK_MHZ = 100;
  // ==========================================
  // Modes
  typedef enum logic [2:0] {
    PDCC_RUN, PDCC_SLEEP, PDCC_SWSTBY, PDCC_SETTLE, PDCC_HWSTBY, PDCC_RESET
  } pdcc_mode_t;
  // Bus request bundle
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pdcc_bus_t;
  // Status bundle
  typedef struct packed {
    logic cpu_halt;
    logic clk_run;
    logic periph_reset;
    logic ports_hiz;
    logic int_start;
    logic reset_start;
  } pdcc_stat_t;
endpackage

// ### pdcc_top.sv
// Power-down mode control with prescaler chain
`timescale 1ns/100ps
// Notes on behaviour
// - Prescaler divides system clock by 2 up to 4096 in powers of two.
// - Duty adjustment applied only when oscillator runs at 5 MHz or faster.
// - Halt with standby select 0 enters sleep; clocks and peripherals run.
// - Halt with standby select 1 enters software standby; peripherals reset.
// - Standby pin low enters hardware standby; ports float, all halts.
// - Standby select stays 1 after interrupt wake; cleared by writing 0, reset low or standby pin low.
// - Settle field selects 8192 to 131072 states; 11x is illegal.
// - System control register is 8-bit read/write; bit 7 and bits 6:4.
// - Sleep ends on interrupt, reset low or standby pin low.
// - Software standby wake waits the settle time, then restarts oscillator and takes interrupt in the same cycle.
// - Hardware standby exit restarts oscillator on pin rise, reset starts later.
module pdcc_top import pdcc_pkg::*; #(
  parameter int OSC_MHZ = PDCC_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire pdcc_bus_t bus,
  output logic [7:0] rdata,
  input wire logic halt_exec,
  input wire logic irq_wake,
  input wire logic nmi_wake,
  input wire logic [2:0] external_request_lines,
  input wire logic standby_pin,
  input wire logic hard_init_pin,
  output logic [PDCC_PRESC_W-1:0] presc_clk,
  output logic duty_adjust_en,
  output pdcc_stat_t stat
);
  // ==========================================
  // Elaboration checks
  if (OSC_MHZ < 1) begin : g_bad_osc
    $error("OSC_MHZ must be positive");
  end
  if (PDCC_SETTLE_W < 18) begin : g_bad_settle
    $error("Settle counter too narrow for the longest wait");
  end
  if (PDCC_PRESC_W != 12) begin : g_bad_presc
    $error("Prescaler chain must reach division by 4096");
  end

  // ==========================================
  // State
  typedef struct packed {
    logic [7:0] system_control_power;
    pdcc_mode_t mode;
    logic [PDCC_PRESC_W-1:0] presc;
    logic [PDCC_SETTLE_W-1:0] settle;
    logic [7:0] rdata;
    pdcc_stat_t stat;
    logic duty;
  } pdcc_state_t;

  pdcc_state_t st_ff;
  pdcc_state_t nxt_st;
  logic [PDCC_SETTLE_W-1:0] wait_len;
  logic [2:0] sts;
  wire logic [PDCC_PRESC_W-1:0] presc_tgl;
  logic sw_wake;
  logic sleep_wake;
  logic reg_wr;
  logic sts_bad;

  // ==========================================
  // Settle length decode
  always_comb begin
    sts = st_ff.system_control_power[PDCC_STS_HI:PDCC_STS_LO];
    if (sts[2]) begin
      wait_len = PDCC_WAIT_BASE << 4;
    end else begin
      wait_len = PDCC_WAIT_BASE << sts[1:0];
    end
  end

  // ==========================================
  // Prescaler chain
  for (genvar k = 0; k < PDCC_PRESC_W; k++) begin : g_stage
    if (k == 0) begin : g_first
      assign presc_tgl[k] = st_ff.stat.clk_run;
    end else begin : g_next
      assign presc_tgl[k] = presc_tgl[k-1] & st_ff.presc[k-1];
    end
  end

  // ==========================================
  // Request decode
  always_comb begin
    reg_wr = bus.wr && bus.addr == PDCC_SYSTEM_CONTROL_POWER_ADDR && st_ff.mode != PDCC_HWSTBY;
    sts_bad = bus.wdata[PDCC_STS_HI:PDCC_STS_LO+1] == 2'b11;
    sw_wake = nmi_wake || (|external_request_lines);
    sleep_wake = irq_wake || nmi_wake;
  end

  // ==========================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = 8'h00;
    nxt_st.duty = (OSC_MHZ >= PDCC_DUTY_MHZ);
    nxt_st.stat.int_start = 1'b0;
    nxt_st.stat.reset_start = 1'b0;
    if (bus.rd && bus.addr == PDCC_SYSTEM_CONTROL_POWER_ADDR) begin
      nxt_st.rdata = st_ff.system_control_power;
    end
    if (reg_wr) begin
      nxt_st.system_control_power = bus.wdata;
      if (sts_bad) begin
        nxt_st.system_control_power[PDCC_STS_HI:PDCC_STS_LO] = st_ff.system_control_power[PDCC_STS_HI:PDCC_STS_LO];
      end
    end
    if (st_ff.stat.clk_run) begin
      nxt_st.presc = st_ff.presc ^ presc_tgl;
    end
    case (st_ff.mode)
      PDCC_RUN: begin
        if (halt_exec) begin
          if (st_ff.system_control_power[PDCC_STANDBY_SELECT_BIT]) begin
            nxt_st.mode = PDCC_SWSTBY;
            nxt_st.stat.clk_run = 1'b0;
            nxt_st.stat.periph_reset = 1'b1;
            nxt_st.presc = '0;
          end else begin
            nxt_st.mode = PDCC_SLEEP;
          end
          nxt_st.stat.cpu_halt = 1'b1;
        end
      end
      PDCC_SLEEP: begin
        if (sleep_wake) begin
          nxt_st.mode = PDCC_RUN;
          nxt_st.stat.cpu_halt = 1'b0;
          nxt_st.stat.int_start = 1'b1;
        end
      end
      PDCC_SWSTBY: begin
        if (sw_wake) begin
          nxt_st.mode = PDCC_SETTLE;
          nxt_st.settle = '0;
        end
      end
      PDCC_SETTLE: begin
        nxt_st.settle = st_ff.settle + 1'b1;
        if (st_ff.settle + 1'b1 >= wait_len) begin
          nxt_st.mode = PDCC_RUN;
          nxt_st.stat.clk_run = 1'b1;
          nxt_st.stat.periph_reset = 1'b0;
          nxt_st.stat.cpu_halt = 1'b0;
          nxt_st.stat.int_start = 1'b1;
        end
      end
      PDCC_HWSTBY: begin
        if (standby_pin) begin
          nxt_st.mode = PDCC_RESET;
          nxt_st.stat.clk_run = 1'b1;
          nxt_st.stat.ports_hiz = 1'b0;
        end
      end
      PDCC_RESET: begin
        if (hard_init_pin) begin
          nxt_st.mode = PDCC_RUN;
          nxt_st.stat.cpu_halt = 1'b0;
          nxt_st.stat.periph_reset = 1'b0;
          nxt_st.stat.reset_start = 1'b1;
        end
      end
      default: nxt_st.mode = PDCC_RESET;
    endcase
    if (!hard_init_pin && st_ff.mode != PDCC_HWSTBY) begin
      nxt_st.mode = PDCC_RESET;
      nxt_st.system_control_power = PDCC_SYSTEM_CONTROL_POWER_RESET;
      nxt_st.stat.cpu_halt = 1'b1;
      nxt_st.stat.clk_run = 1'b1;
      nxt_st.stat.periph_reset = 1'b1;
      nxt_st.stat.int_start = 1'b0;
    end
    if (!standby_pin) begin
      nxt_st.mode = PDCC_HWSTBY;
      nxt_st.system_control_power = PDCC_SYSTEM_CONTROL_POWER_RESET;
      nxt_st.presc = '0;
      nxt_st.stat.cpu_halt = 1'b1;
      nxt_st.stat.clk_run = 1'b0;
      nxt_st.stat.periph_reset = 1'b1;
      nxt_st.stat.ports_hiz = 1'b1;
      nxt_st.stat.int_start = 1'b0;
      nxt_st.stat.reset_start = 1'b0;
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_ff.system_control_power <= PDCC_SYSTEM_CONTROL_POWER_RESET;
      st_ff.mode <= PDCC_RUN;
      st_ff.presc <= '0;
      st_ff.settle <= '0;
      st_ff.rdata <= 8'h00;
      st_ff.stat.cpu_halt <= 1'b0;
      st_ff.stat.clk_run <= 1'b1;
      st_ff.stat.periph_reset <= 1'b0;
      st_ff.stat.ports_hiz <= 1'b0;
      st_ff.stat.int_start <= 1'b0;
      st_ff.stat.reset_start <= 1'b0;
      st_ff.duty <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================
  // Outputs
  assign rdata = st_ff.rdata;
  assign presc_clk = st_ff.presc;
  assign duty_adjust_en = st_ff.duty;
  assign stat = st_ff.stat;
endmodule

// ### pdcc_chk.sv
// Checker for power-down and clock control
`timescale 1ns/100ps
module pdcc_chk import pdcc_pkg::*; #(
  parameter int OSC_MHZ = PDCC_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire pdcc_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic irq_wake,
  input wire logic standby_pin,
  input wire logic hard_init_pin,
  input wire logic [PDCC_PRESC_W-1:0] presc_clk,
  input wire logic duty_adjust_en,
  input wire pdcc_stat_t stat
);
  // ==========
  // Properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence hw_exit_s;
    stat.ports_hiz && !hard_init_pin ##1 standby_pin;
  endsequence
  sequence init_rel_s;
    (!hard_init_pin && standby_pin)[*2] ##1 hard_init_pin;
  endsequence
  presc_step_a: assert property ($past(rstn) && hard_init_pin && $past(hard_init_pin)
    && stat.clk_run && $past(stat.clk_run) |-> presc_clk == $past(presc_clk) + 12'h001)
    else $error("prescaler step");
  rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("rdata idle");
  duty_sel_a: assert property ($past(rstn) |-> duty_adjust_en == (OSC_MHZ >= 5))
    else $error("duty select");
  hw_entry_a: assert property (!standby_pin |-> ##[1:2] stat.ports_hiz)
    else $error("hw standby entry");
  hw_exit_a: assert property (hw_exit_s |-> ##[0:1] stat.clk_run && !stat.ports_hiz)
    else $error("hw standby exit");
  init_exit_a: assert property (init_rel_s |-> ##[0:1] stat.reset_start)
    else $error("reset start");
  sleep_run_a: assert property (hard_init_pin && $past(hard_init_pin) && stat.cpu_halt
    && stat.clk_run |-> !stat.periph_reset && !stat.ports_hiz) else $error("sleep state");
  sw_reset_a: assert property (stat.cpu_halt && !stat.clk_run |-> stat.periph_reset)
    else $error("standby reset");
  int_pulse_a: assert property (stat.int_start |=> !stat.int_start)
    else $error("int pulse");
  sleep_wake_a: assert property (stat.cpu_halt && stat.clk_run && irq_wake && standby_pin
    && hard_init_pin |-> ##[1:2] !stat.cpu_halt) else $error("sleep wake");
endmodule
bind pdcc_top pdcc_chk #(.OSC_MHZ(OSC_MHZ)) u_chk (.core_clk(core_clk), .rstn(rstn),
  .bus(bus), .rdata(rdata), .irq_wake(irq_wake), .standby_pin(standby_pin),
  .hard_init_pin(hard_init_pin), .presc_clk(presc_clk), .duty_adjust_en(duty_adjust_en),
  .stat(stat));

// ### pdcc_tb.sv
// Testbench for power-down and clock control
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module pdcc_tb import pdcc_pkg::*;;
  logic core_clk = 0, rstn = 0, halt_exec = 0, irq_wake = 0, nmi_wake = 0;
  logic standby_pin = 1, hard_init_pin = 1;
  logic [2:0] ext_req = 3'h0;
  pdcc_bus_t bus = '0;
  logic [7:0] rdata;
  logic [11:0] presc_clk;
  logic duty_adjust_en;
  pdcc_stat_t stat;
  int failures = 0, n_compared = 0;
  pdcc_top dut (.core_clk(core_clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .halt_exec(halt_exec), .irq_wake(irq_wake), .nmi_wake(nmi_wake),
    .external_request_lines(ext_req), .standby_pin(standby_pin),
    .hard_init_pin(hard_init_pin), .presc_clk(presc_clk), .duty_adjust_en(duty_adjust_en),
    .stat(stat));
  // ==========
  // Tasks
  task automatic cyc(int n); repeat (n) @(posedge core_clk); endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    cyc(1);
    bus <= '0;
    cyc(1);
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    cyc(1);
    bus <= '0;
    @(negedge core_clk);
    `CHK("rdata", e, rdata)
    cyc(1);
  endtask
  task automatic halt;
    halt_exec <= 1;
    cyc(1);
    halt_exec <= 0;
    cyc(2);
    @(negedge core_clk);
  endtask
  task automatic t_reg;
    rd(16'hfff2, 8'h0b);
    wr(16'hfff2, 8'h5a);
    rd(16'hfff2, 8'h5a);
    wr(16'hfff2, 8'hf0);
    rd(16'hfff2, 8'hd0);
    wr(16'h0f00, 8'hff);
    rd(16'h0f00, 8'h00);
  endtask
  task automatic t_presc;
    logic [11:0] p0;
    @(negedge core_clk);
    p0 = presc_clk;
    `CHK("duty", 1'b1, duty_adjust_en)
    cyc(16);
    @(negedge core_clk);
    `CHK("presc", p0 + 12'h010, presc_clk)
    cyc(1);
  endtask
  task automatic t_sleep;
    wr(16'hfff2, 8'h0b);
    halt;
    `CHK("sleep", 2'b11, {stat.cpu_halt, stat.clk_run})
    cyc(1);
    irq_wake <= 1;
    cyc(2);
    @(negedge core_clk);
    `CHK("wake", 1'b0, stat.cpu_halt)
    cyc(1);
    irq_wake <= 0;
  endtask
  task automatic t_swstby;
    int n = 0;
    wr(16'hfff2, 8'h8b);
    halt;
    `CHK("swstby", 3'b101, {stat.cpu_halt, stat.clk_run, stat.periph_reset})
    `CHK("frozen", 12'h000, presc_clk)
    cyc(1);
    ext_req <= 3'h4;
    cyc(1);
    ext_req <= 3'h0;
    while (stat.int_start !== 1'b1 && n < 9000) begin @(negedge core_clk); n++; end
    `CHK("settle", 1'b1, n >= 8190 && n <= 8196)
    `CHK("resume", 3'b100, {stat.clk_run, stat.periph_reset, stat.cpu_halt})
    cyc(1);
    rd(16'hfff2, 8'h8b);
  endtask
  task automatic t_hw;
    wr(16'hfff2, 8'h0a);
    standby_pin <= 0;
    cyc(3);
    @(negedge core_clk);
    `CHK("hiz", 1'b1, stat.ports_hiz)
    cyc(1);
    hard_init_pin <= 0;
    cyc(1);
    standby_pin <= 1;
    cyc(3);
    @(negedge core_clk);
    `CHK("osc", 2'b10, {stat.clk_run, stat.ports_hiz})
    cyc(1);
    hard_init_pin <= 1;
    cyc(1);
    @(negedge core_clk);
    `CHK("rstart", 1'b1, stat.reset_start)
    cyc(2);
    rd(16'hfff2, 8'h0b);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========
  // Sequence
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    cyc(2);
    rstn <= 1;
    cyc(1);
    t_reg;
    t_presc;
    t_sleep;
    t_swstby;
    t_hw;
    tally_and_finish;
  end
  initial begin
    #300000;
    failures++;
    tally_and_finish;
  end
endmodule
